// ===== hw/abd_consts.svh
/*
 Register map, field positions, reset values and identity words of the audio DAC register bank.
 Assumes inclusion by bare name from the package only; the bank module does not include it.
*/
// Function
// - Channel-1 sample is two's complement.
// - Compact stereo formats ignore channel-1 word.
// - Channel-0 mute bit 31 mutes channel.
// - Channel-0 volume is 15-bit field.
// - Channel-1 mute bit 31 mutes channel.
// - Channel-1 volume is 15-bit field.
// - Enable-set writes ones into mask.
// - Enable-clear writes clear mask bits.
// - Mask: underrun bit 2, ready bit 1.
// - Underrun flag sticky until clear or reset.
// - Ready flag shows sample can be accepted.
// - Busy bit 0 during domain transfer.
// - Status-clear ones clear flag and request.
// - Parameter word reads its reset value.
// - Version word: revision and variant fields.
`ifndef ABD_CONSTS_SVH
`define ABD_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ABD_OFS_CTRL 6'h00
`define ABD_OFS_SMP0 6'h04
`define ABD_OFS_SMP1 6'h08
`define ABD_OFS_VOL0 6'h0C
`define ABD_OFS_VOL1 6'h10
`define ABD_OFS_IES 6'h14
`define ABD_OFS_IEC 6'h18
`define ABD_OFS_IMS 6'h1C
`define ABD_OFS_STAT 6'h20
`define ABD_OFS_SCLR 6'h24
`define ABD_OFS_FEAT 6'h28
`define ABD_OFS_REV 6'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ABD_MUTE_BIT 31
`define ABD_VOL_MSB 14
`define ABD_BUSY_BIT 0
`define ABD_RDY_BIT 1
`define ABD_UR_BIT 2
`define ABD_FMT_LSB 16
`define ABD_FMT_MSB 18
`define ABD_SWRST_BIT 7
`define ABD_EN_BIT 0
`define ABD_FMT_C16 3'h5
`define ABD_FMT_C8 3'h7

// ----------------------------------------------------------------
// Reset and identity values
// ----------------------------------------------------------------
`define ABD_ZERO32 32'h0000_0000
`define ABD_IRQ_MASK 3'h6
`define ABD_FEAT_RST 32'h0000_0000
// Identity values are arbitrary
`define ABD_REV_NUM 12'h0A5
`define ABD_VARIANT 4'h3
// Cycles the domain hand-over keeps busy high
`define ABD_XFER_CYC 3'h3

`endif

// ===== hw/abd_pkg.sv
/*
 Types shared by the audio DAC register bank.
 Assumes the constants header is on the include path.
*/
package abd_pkg;
`include "abd_consts.svh"

    typedef struct packed {
        logic mute;
        logic [14:0] volume;
    } abd_vol_t;

    typedef struct packed {
        logic underrun;
        logic ready;
        logic busy;
    } abd_stat_t;

    typedef struct packed {
        logic [31:0] ch0;
        logic [31:0] ch1;
        logic ch1_used;
    } abd_sample_t;

    typedef enum logic [1:0] {
        ABD_IDLE,
        ABD_XFER
    } abd_xfer_state_t;
endpackage : abd_pkg

// ===== hw/abd_regbank.sv
/*
 Register bank of the audio bitstream DAC: sample words, volume, interrupt mask,
 status, identity. Classic Wishbone slave, answers every access one cycle after
 the request appears. Assumes the datapath pulses SAMPLE_REQ when it takes a pair.
*/
`timescale 1ns/100ps
module abd_regbank
    import abd_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic SAMPLE_REQ,
    output logic [31:0] CH0_SAMPLE,
    output logic [31:0] CH1_SAMPLE,
    output logic CH0_MUTE,
    output logic [14:0] CH0_VOLUME,
    output logic CH1_MUTE,
    output logic [14:0] CH1_VOLUME,
    output logic DAC_ENABLE,
    output logic [2:0] SAMPLE_FORMAT,
    output logic IRQ
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic rd;
    logic ack_q;
    logic soft_rst_q;
    logic rst;

    assign req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wr = req && WB_WE_I;
    assign rd = req && !WB_WE_I;
    assign rst = RESET || soft_rst_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic hit(input logic [5:0] adr, input logic [5:0] ofs);
        return adr[5:2] == ofs[5:2];
    endfunction : hit

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end
    assign WB_ACK_O = ack_q;

    // ------------------------------------------------------------
    // Control word and samples
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] smp0_q;
    logic [31:0] smp1_q;
    logic busy;
    logic compact;
    logic [1:0] fresh_q;

    // Soft reset: self-clearing one-cycle pulse that resets the whole bank except the bus acknowledge
    always_ff @(posedge MCLK) begin
        if (rst) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr && hit(WB_ADR_I, `ABD_OFS_CTRL) && WB_SEL_I[0]
                && WB_DAT_I[`ABD_SWRST_BIT];
        end
    end

    // Control and sample writes during busy are dropped, matching the hand-over hazard
    always_ff @(posedge MCLK) begin
        if (rst) begin
            ctrl_q <= `ABD_ZERO32;
            smp0_q <= `ABD_ZERO32;
            smp1_q <= `ABD_ZERO32;
        end else if (wr && !busy) begin
            if (hit(WB_ADR_I, `ABD_OFS_CTRL)) begin
                ctrl_q <= merge(ctrl_q, WB_DAT_I, WB_SEL_I);
            end
            if (hit(WB_ADR_I, `ABD_OFS_SMP0)) begin
                smp0_q <= merge(smp0_q, WB_DAT_I, WB_SEL_I);
            end
            if (hit(WB_ADR_I, `ABD_OFS_SMP1)) begin
                smp1_q <= merge(smp1_q, WB_DAT_I, WB_SEL_I);
            end
        end
    end

    assign compact = (ctrl_q[`ABD_FMT_MSB:`ABD_FMT_LSB] == `ABD_FMT_C16)
        || (ctrl_q[`ABD_FMT_MSB:`ABD_FMT_LSB] == `ABD_FMT_C8);

    // ------------------------------------------------------------
    // Volume
    // ------------------------------------------------------------
    abd_vol_t vol0_q;
    abd_vol_t vol1_q;

    always_ff @(posedge MCLK) begin
        if (rst) begin
            vol0_q <= '0;
        end else if (wr && hit(WB_ADR_I, `ABD_OFS_VOL0)) begin
            if (WB_SEL_I[3]) begin
                vol0_q.mute <= WB_DAT_I[`ABD_MUTE_BIT];
            end
            if (WB_SEL_I[0]) begin
                vol0_q.volume[7:0] <= WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1]) begin
                vol0_q.volume[`ABD_VOL_MSB:8] <= WB_DAT_I[`ABD_VOL_MSB:8];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (rst) begin
            vol1_q <= '0;
        end else if (wr && hit(WB_ADR_I, `ABD_OFS_VOL1)) begin
            if (WB_SEL_I[3]) begin
                vol1_q.mute <= WB_DAT_I[`ABD_MUTE_BIT];
            end
            if (WB_SEL_I[0]) begin
                vol1_q.volume[7:0] <= WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1]) begin
                vol1_q.volume[`ABD_VOL_MSB:8] <= WB_DAT_I[`ABD_VOL_MSB:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Sample hand-over to the datapath
    // ------------------------------------------------------------
    abd_xfer_state_t xst_q;
    logic [2:0] xcnt_q;
    logic take;

    // The datapath takes a pair only while enabled
    assign take = SAMPLE_REQ && ctrl_q[`ABD_EN_BIT] && xst_q == ABD_IDLE;

    always_ff @(posedge MCLK) begin
        if (rst) begin
            xst_q <= ABD_IDLE;
            xcnt_q <= 3'h0;
        end else begin
            case (xst_q)
                ABD_IDLE: begin
                    if (take) begin
                        xst_q <= ABD_XFER;
                        xcnt_q <= `ABD_XFER_CYC;
                    end
                end
                ABD_XFER: begin
                    if (xcnt_q == 3'h1) begin
                        xst_q <= ABD_IDLE;
                    end
                    xcnt_q <= xcnt_q - 3'h1;
                end
                default: begin
                    xst_q <= ABD_IDLE;
                end
            endcase
        end
    end
    assign busy = xst_q == ABD_XFER;

    // Fresh marks: bit 0 channel-0 word, bit 1 channel-1 word
    always_ff @(posedge MCLK) begin
        if (rst) begin
            fresh_q <= 2'b00;
        end else begin
            if (take) begin
                fresh_q <= 2'b00;
            end
            if (wr && !busy && hit(WB_ADR_I, `ABD_OFS_SMP0)) begin
                fresh_q[0] <= 1'b1;
            end
            if (wr && !busy && hit(WB_ADR_I, `ABD_OFS_SMP1)) begin
                fresh_q[1] <= 1'b1;
            end
        end
    end

    abd_sample_t out_q;
    always_ff @(posedge MCLK) begin
        if (rst) begin
            out_q <= '0;
        end else if (take) begin
            out_q.ch0 <= smp0_q;
            out_q.ch1 <= compact ? `ABD_ZERO32 : smp1_q;
            out_q.ch1_used <= !compact;
        end
    end

    // ------------------------------------------------------------
    // Status, mask, interrupt
    // ------------------------------------------------------------
    logic [2:0] mask_q;
    logic ur_q;
    logic ready;
    logic underrun_ev;
    logic irq_q;

    // Ready once every word the format needs is written
    assign ready = !busy && fresh_q[0] && (compact || fresh_q[1]);
    assign underrun_ev = take && !ready;

    always_ff @(posedge MCLK) begin
        if (rst) begin
            mask_q <= 3'h0;
        end else if (wr && hit(WB_ADR_I, `ABD_OFS_IES) && WB_SEL_I[0]) begin
            mask_q <= mask_q | (WB_DAT_I[2:0] & `ABD_IRQ_MASK);
        end else if (wr && hit(WB_ADR_I, `ABD_OFS_IEC) && WB_SEL_I[0]) begin
            mask_q <= mask_q & ~(WB_DAT_I[2:0] & `ABD_IRQ_MASK);
        end
    end

    // A new underrun in the clearing cycle wins over the clear
    always_ff @(posedge MCLK) begin
        if (rst) begin
            ur_q <= 1'b0;
        end else if (underrun_ev) begin
            ur_q <= 1'b1;
        end else if (wr && hit(WB_ADR_I, `ABD_OFS_SCLR) && WB_SEL_I[0]
                     && WB_DAT_I[`ABD_UR_BIT]) begin
            ur_q <= 1'b0;
        end
    end

    // Ready is a live level, so its clear has nothing to hold down
    abd_stat_t stat;
    assign stat = '{underrun: ur_q, ready: ready, busy: busy};

    always_ff @(posedge MCLK) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |({stat.underrun, stat.ready, 1'b0} & mask_q);
        end
    end
    assign IRQ = irq_q;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;

    always_comb begin
        rdat_d = `ABD_ZERO32;
        case (WB_ADR_I & 6'h3C)
            `ABD_OFS_CTRL: rdat_d = ctrl_q;
            `ABD_OFS_SMP0: rdat_d = smp0_q;
            `ABD_OFS_SMP1: rdat_d = smp1_q;
            `ABD_OFS_VOL0: rdat_d = {vol0_q.mute, 16'h0000, vol0_q.volume};
            `ABD_OFS_VOL1: rdat_d = {vol1_q.mute, 16'h0000, vol1_q.volume};
            `ABD_OFS_IMS: rdat_d = {29'h0000_0000, mask_q};
            `ABD_OFS_STAT: rdat_d = {29'h0000_0000, stat};
            `ABD_OFS_FEAT: rdat_d = `ABD_FEAT_RST;
            `ABD_OFS_REV: rdat_d = {12'h000, `ABD_VARIANT, 4'h0, `ABD_REV_NUM};
            default: rdat_d = `ABD_ZERO32;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (rst) begin
            rdat_q <= `ABD_ZERO32;
        end else if (rd) begin
            rdat_q <= rdat_d;
        end
    end
    assign WB_DAT_O = rdat_q;

    // ------------------------------------------------------------
    // Datapath outputs
    // ------------------------------------------------------------
    assign CH0_SAMPLE = out_q.ch0;
    assign CH1_SAMPLE = out_q.ch1;
    assign CH0_MUTE = vol0_q.mute;
    assign CH0_VOLUME = vol0_q.volume;
    assign CH1_MUTE = vol1_q.mute;
    assign CH1_VOLUME = vol1_q.volume;
    assign DAC_ENABLE = ctrl_q[`ABD_EN_BIT];
    assign SAMPLE_FORMAT = ctrl_q[`ABD_FMT_MSB:`ABD_FMT_LSB];

endmodule : abd_regbank

// ===== bench/abd_regbank_monitor.sv
/*
 Port checker for the audio DAC register bank.
 Assumes one clock MCLK, a synchronous RESET and full-lane bus accesses.
*/
`timescale 1ns/100ps
module abd_regbank_monitor (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic SAMPLE_REQ,
    input wire logic [31:0] CH0_SAMPLE,
    input wire logic [31:0] CH1_SAMPLE,
    input wire logic CH0_MUTE,
    input wire logic [14:0] CH0_VOLUME,
    input wire logic CH1_MUTE,
    input wire logic [14:0] CH1_VOLUME,
    input wire logic DAC_ENABLE,
    input wire logic [2:0] SAMPLE_FORMAT,
    input wire logic IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    // ------------------------------------------------------------
    // Mask shadow
    // ------------------------------------------------------------
    // Soft reset is not tracked: a mask read after it would mislead
    logic [1:0] mask_q;
    wire wr_ack = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
    always_ff @(posedge MCLK) begin
        if (RESET) mask_q <= 2'h0;
        else if (wr_ack && WB_ADR_I[5:2] == 4'h5) mask_q <= mask_q | WB_DAT_I[2:1];
        else if (wr_ack && WB_ADR_I[5:2] == 4'h6) mask_q <= mask_q & ~WB_DAT_I[2:1];
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_acc(logic w, logic [3:0] word);
        WB_CYC_I && WB_STB_I && WB_WE_I == w && WB_ADR_I[5:2] == word
            && WB_SEL_I == 4'hF && WB_ACK_O;
    endsequence

    a_ack_follows: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_vol0_write: assert property (
        s_acc(1'b1, 4'h3) |=> CH0_MUTE == $past(WB_DAT_I[31])
            && CH0_VOLUME == $past(WB_DAT_I[14:0])) else $error("channel 0 volume wrong");
    a_vol1_write: assert property (
        s_acc(1'b1, 4'h4) |=> CH1_MUTE == $past(WB_DAT_I[31])
            && CH1_VOLUME == $past(WB_DAT_I[14:0])) else $error("channel 1 volume wrong");
    a_mask_read: assert property (
        s_acc(1'b0, 4'h7) |-> WB_DAT_O == {29'h0, mask_q, 1'b0}) else $error("mask read wrong");
    a_irq_masked: assert property (
        IRQ |-> mask_q != 2'h0) else $error("interrupt with no enable");
    a_compact_ch1: assert property (
        $changed(CH0_SAMPLE) && SAMPLE_FORMAT inside {3'h5, 3'h7} |-> CH1_SAMPLE == 32'h0)
        else $error("channel 1 used in compact format");
    a_feature_zero: assert property (
        s_acc(1'b0, 4'hA) |-> WB_DAT_O == 32'h0) else $error("feature word not zero");
    a_revision_form: assert property (
        s_acc(1'b0, 4'hB) |-> WB_DAT_O[31:20] == 12'h0 && WB_DAT_O[15:12] == 4'h0)
        else $error("revision reserved bits set");
endmodule : abd_regbank_monitor

bind abd_regbank abd_regbank_monitor u_abd_regbank_monitor (
    .MCLK(MCLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SAMPLE_REQ(SAMPLE_REQ),
    .CH0_SAMPLE(CH0_SAMPLE), .CH1_SAMPLE(CH1_SAMPLE), .CH0_MUTE(CH0_MUTE),
    .CH0_VOLUME(CH0_VOLUME), .CH1_MUTE(CH1_MUTE), .CH1_VOLUME(CH1_VOLUME),
    .DAC_ENABLE(DAC_ENABLE), .SAMPLE_FORMAT(SAMPLE_FORMAT), .IRQ(IRQ)
);

// ===== bench/tb.sv
/*
 Self-checking bench for the audio DAC register bank.
 Assumes the bank answers each bus access by itself; the bench plays the datapath.
*/
`timescale 1ns/100ps
module tb;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, ack, m0, m1, en, irq;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, dat_o, ch0, ch1;
    logic [14:0] v0, v1;
    logic [2:0] fmt;
    logic [5:0] zero_ofs [5] = '{6'h0C, 6'h10, 6'h1C, 6'h20, 6'h28};
    int n_errors = 0;
    int check_count = 0;

    always #20 MCLK = ~MCLK;

    abd_regbank u_abd_regbank (
        .MCLK(MCLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .SAMPLE_REQ(req), .CH0_SAMPLE(ch0), .CH1_SAMPLE(ch1),
        .CH0_MUTE(m0), .CH0_VOLUME(v0), .CH1_MUTE(m1), .CH1_VOLUME(v1),
        .DAC_ENABLE(en), .SAMPLE_FORMAT(fmt), .IRQ(irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge MCLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        while (ack !== 1'b1) begin
            @(posedge MCLK);
            n++;
            if (n > 20) begin
                n_errors++;
                end_of_test();
            end
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : acc

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
        acc(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdat);
    endtask : rd

    // Datapath asks for one pair
    task automatic take();
        @(posedge MCLK);
        req <= 1'b1;
        @(posedge MCLK);
        req <= 1'b0;
    endtask : take

    // IRQ is registered behind the mask, so let two edges pass
    task automatic irq_is(input logic e);
        repeat (2) @(posedge MCLK);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_is

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge MCLK);
        RESET <= 1'b0;
        for (int i = 0; i < 5; i++) rd(zero_ofs[i], 32'h0000_0000, "reset");
        rd(6'h2C, 32'h0003_00A5, "revision");
        wr(6'h30, 32'hFFFF_FFFF);
        rd(6'h30, 32'h0000_0000, "unmapped");
        wr(6'h0C, 32'h8000_7FFF);
        wr(6'h10, 32'h0000_1234);
        rd(6'h0C, 32'h8000_7FFF, "vol0");
        chk("mute1", 32'h0, {31'h0, m1});
        chk("volume1", 32'h1234, {17'h0, v1});
        wr(6'h0C, 32'h0000_0000);
        chk("mute0", 32'h0, {31'h0, m0});
        wr(6'h14, 32'h0000_0006);
        rd(6'h1C, 32'h0000_0006, "mask");
        wr(6'h18, 32'h0000_0002);
        wr(6'h14, 32'h0000_0000);
        wr(6'h18, 32'h0000_0000);
        wr(6'h1C, 32'h0000_0006);
        rd(6'h1C, 32'h0000_0004, "mask");
        wr(6'h00, 32'h0000_0001);
        wr(6'h04, 32'h8000_0001);
        rd(6'h20, 32'h0000_0000, "status");
        wr(6'h08, 32'h7FFF_FFFF);
        rd(6'h20, 32'h0000_0002, "status");
        take();
        rd(6'h20, 32'h0000_0001, "status");
        chk("ch0", 32'h8000_0001, ch0);
        chk("ch1", 32'h7FFF_FFFF, ch1);
        repeat (2) @(posedge MCLK);
        take();
        repeat (4) @(posedge MCLK);
        rd(6'h20, 32'h0000_0004, "status");
        irq_is(1'b1);
        wr(6'h24, 32'h0000_0000);
        rd(6'h20, 32'h0000_0004, "status");
        wr(6'h18, 32'h0000_0004);
        irq_is(1'b0);
        wr(6'h14, 32'h0000_0004);
        irq_is(1'b1);
        wr(6'h24, 32'h0000_0004);
        rd(6'h20, 32'h0000_0000, "status");
        irq_is(1'b0);
        for (int f = 5; f <= 7; f += 2) begin
            wr(6'h00, {13'h0, 3'(f), 16'h0001});
            wr(6'h04, 32'hABCD_1234);
            rd(6'h20, 32'h0000_0002, "status");
            take();
            repeat (4) @(posedge MCLK);
            chk("ch0", 32'hABCD_1234, ch0);
            chk("ch1", 32'h0000_0000, ch1);
        end
        wr(6'h00, 32'h0000_0080);
        repeat (2) @(posedge MCLK);
        rd(6'h10, 32'h0000_0000, "vol1");
        end_of_test();
    end
endmodule : tb
